// File: include/odr_pkg.sv
// Package of the orientation detection block: register map, field layout,
// reset values, angle thresholds and the settle time step figures.
// Assumes the register port and the acceleration front end share one clock.
package odr_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] ORIENTATION_STATUS = 8'h10;
  localparam logic [7:0] ORIENTATION_CONFIG = 8'h11;
  localparam logic [7:0] ORIENTATION_SETTLE_COUNT = 8'h12;
  localparam logic [7:0] FACING_AND_TILT_ANGLES = 8'h13;
  localparam logic [7:0] ORIENTATION_THRESHOLD_HYSTERESIS = 8'h14;

  // Status field positions.
  localparam int STAT_CHANGE_BIT = 7;
  localparam int STAT_TILT_BIT = 6;
  localparam int STAT_ORIENT_HI = 2;
  localparam int STAT_ORIENT_LO = 1;
  localparam int STAT_FACING_BIT = 0;

  // Configuration field positions and reset values.
  localparam int CFG_MODE_BIT = 7;
  localparam int CFG_ENABLE_BIT = 6;
  localparam logic CFG_MODE_RESET = 1'b1;
  localparam logic CFG_ENABLE_RESET = 1'b0;
  localparam logic [7:0] SETTLE_COUNT_RESET = 8'h00;

  // Screen orientation codes.
  typedef enum logic [1:0] {
    ODR_PORTRAIT_UP = 2'b00,
    ODR_PORTRAIT_DOWN = 2'b01,
    ODR_LANDSCAPE_RIGHT = 2'b10,
    ODR_LANDSCAPE_LEFT = 2'b11
  } odr_orient_type;

  // Fixed read-only codes.
  localparam logic [1:0] FACING_TRIP_CODE = 2'b01;
  localparam logic [2:0] STEEP_ANGLE_CODE = 3'b100;
  localparam logic [4:0] ORIENTATION_TRIP_CODE = 5'b1_0000;
  localparam logic [2:0] ANGLE_MARGIN_CODE = 3'b100;

  // Angles in degrees used by the candidate evaluation.
  localparam logic [6:0] FACING_TRIP_DEG = 7'h4b;
  localparam logic [6:0] STEEP_ANGLE_DEG = 7'h1d;
  localparam logic [6:0] TO_PORTRAIT_DEG = 7'h3b;
  localparam logic [6:0] TO_LANDSCAPE_DEG = 7'h1f;

  // Sample rate selection codes, fastest first.
  localparam logic [2:0] RATE_800 = 3'h0;
  localparam logic [2:0] RATE_400 = 3'h1;
  localparam logic [2:0] RATE_200 = 3'h2;
  localparam logic [2:0] RATE_100 = 3'h3;
  localparam logic [2:0] RATE_50 = 3'h4;
  localparam logic [2:0] RATE_12P5 = 3'h5;

  // Oversampling mode codes.
  typedef enum logic [1:0] {
    ODR_OS_NORMAL = 2'b00,
    ODR_OS_QUIET_LOW_POWER = 2'b01,
    ODR_OS_HIGH_RES = 2'b10,
    ODR_OS_LOW_POWER = 2'b11
  } odr_os_type;

  // Settle time step in microseconds.
  localparam logic [17:0] STEP_1250_US = 18'h004e2;
  localparam logic [17:0] STEP_2500_US = 18'h009c4;
  localparam logic [17:0] STEP_5000_US = 18'h01388;
  localparam logic [17:0] STEP_10000_US = 18'h02710;
  localparam logic [17:0] STEP_20000_US = 18'h04e20;
  localparam logic [17:0] STEP_80000_US = 18'h13880;
  localparam logic [17:0] STEP_160000_US = 18'h27100;

endpackage : odr_pkg

// File: design/orientation_detect_regs.sv
// Orientation detection with its five registers on the serial register port.
// Assumes the angle and over-range inputs come from the acceleration front
// end on the same clock, qualified by sampleStrobe once per output sample.
//
// Summary of operation
// R1: Status read clears change flag and event.
// R2: Change flag set on first detect or change.
// R3: Fields keep updating while change flag set.
// R4: Any axis over 1.25 g holds orientation.
// R5: Orientation codes in bits 2:1.
// R6: Facing bit 0, 0 front, 1 back.
// R7: Steep tilt flag bit 6 on lockout.
// R8: Status fields and flag zero after reset.
// R9: Mode bit: 0 decrements, 1 clears counter.
// R10: Detection runs only when enable bit set.
// R11: Eight-bit settle count, reset zero.
// R12: Wake/sleep transition resets settle counter.
// R13: Time step from rate and oversampling mode.
// R14: Read-only facing trip code 01.
// R15: Read-only steep angle code 100.
// R16: Read-only trip code 1_0000, margin 100.
// R17: Landscape to portrait 59, reverse 31.
// R18: Candidate per sample, update after count.
// R19: Status and fixed registers ignore writes.
`timescale 1ns/10ps
module orientation_detect_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic sampleStrobe,
  input wire logic activeMode,
  input wire logic sleepMode,
  input wire logic [2:0] sampleRate,
  input wire logic [1:0] osMode,
  input wire logic [2:0] axisOverRange,
  input wire logic [6:0] portraitAngle,
  input wire logic portraitInverted,
  input wire logic landscapeLeft,
  input wire logic [6:0] facingAngle,
  input wire logic facingBackward,
  input wire logic [6:0] screenElevation,
  output logic orientationEvent,
  output logic [17:0] settleStepUs
);

  logic orientationChangeFlag_r;
  logic steepTiltFlag_r;
  logic [1:0] screenOrientation_r;
  logic facingSide_r;
  logic settleCounterMode_r;
  logic orientationEnable_r;
  logic [7:0] settleCountValue_r;
  logic [7:0] settleCnt_r;
  logic [7:0] settleCnt_nxt;
  logic firstPending_r;
  logic activeDly_r;
  logic sleepDly_r;
  logic [1:0] candOrient;
  logic candFacing;
  logic candTilt;
  logic overG;
  logic differs;
  logic evalNow;
  logic doUpdate;
  logic statusRead;
  logic wakeSleepEdge;
  logic newEvent;
  logic wrConfig;
  logic wrCount;
  logic [7:0] rdMux;

  // Settle time step for a sample rate and oversampling mode.
  function automatic logic [17:0] step_us(input logic [2:0] rate, input logic [1:0] os);
    logic [17:0] s;
    s = odr_pkg::STEP_20000_US;
    if (rate == odr_pkg::RATE_800) begin
      s = odr_pkg::STEP_1250_US;
    end else if (rate == odr_pkg::RATE_400 || os == odr_pkg::ODR_OS_HIGH_RES) begin
      s = odr_pkg::STEP_2500_US;
    end else if (rate == odr_pkg::RATE_200) begin
      s = odr_pkg::STEP_5000_US;
    end else if (rate == odr_pkg::RATE_100) begin
      s = odr_pkg::STEP_10000_US;
    end else if (rate == odr_pkg::RATE_50 || os == odr_pkg::ODR_OS_NORMAL) begin
      s = odr_pkg::STEP_20000_US;
    end else if (rate == odr_pkg::RATE_12P5 || os == odr_pkg::ODR_OS_QUIET_LOW_POWER) begin
      s = odr_pkg::STEP_80000_US;
    end else begin
      s = odr_pkg::STEP_160000_US;
    end
    return s;
  endfunction : step_us

  // Register address match, used by both the read and the write paths.
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] offset);
    return a == offset;
  endfunction : addr_is

  // Portrait code for the sensed inversion.
  function automatic logic [1:0] portrait_code(input logic inverted);
    logic [1:0] c;
    c = odr_pkg::ODR_PORTRAIT_UP;
    if (inverted) begin
      c = odr_pkg::ODR_PORTRAIT_DOWN;
    end
    return c;
  endfunction : portrait_code

  // Landscape code for the sensed side.
  function automatic logic [1:0] landscape_code(input logic left);
    logic [1:0] c;
    c = odr_pkg::ODR_LANDSCAPE_RIGHT;
    if (left) begin
      c = odr_pkg::ODR_LANDSCAPE_LEFT;
    end
    return c;
  endfunction : landscape_code

  // Strobes are qualified by the clock enable so a frozen block takes nothing.
  assign statusRead = ce && regRdEn && addr_is(regAddr, odr_pkg::ORIENTATION_STATUS);
  assign wrConfig = ce && regWrEn && addr_is(regAddr, odr_pkg::ORIENTATION_CONFIG);
  assign wrCount = ce && regWrEn && addr_is(regAddr, odr_pkg::ORIENTATION_SETTLE_COUNT);
  assign wakeSleepEdge = sleepMode != sleepDly_r;
  assign overG = |axisOverRange;
  assign evalNow = sampleStrobe && activeMode && orientationEnable_r && !overG; // R4 R10 R18

  // Candidate steep tilt: screen plane too close to horizontal.
  assign candTilt = screenElevation < odr_pkg::STEEP_ANGLE_DEG; // R7

  // Candidate facing: flips only past the trip angle, otherwise held.
  always_comb begin
    candFacing = facingSide_r;
    if (facingAngle >= odr_pkg::FACING_TRIP_DEG) begin
      candFacing = facingBackward; // R6 R14
    end
  end

  // Candidate orientation with hysteresis around the 45 degree threshold.
  always_comb begin
    candOrient = screenOrientation_r;
    if (candTilt) begin
      candOrient = screenOrientation_r;
    end else if (!screenOrientation_r[1]) begin
      // In portrait the angle must fall below the lower trip to leave.
      if (portraitAngle < odr_pkg::TO_LANDSCAPE_DEG) begin
        candOrient = landscape_code(landscapeLeft); // R17 R5
      end else begin
        candOrient = portrait_code(portraitInverted);
      end
    end else begin
      // In landscape the angle must rise above the upper trip to leave.
      if (portraitAngle > odr_pkg::TO_PORTRAIT_DEG) begin
        candOrient = portrait_code(portraitInverted); // R17 R5
      end else begin
        candOrient = landscape_code(landscapeLeft);
      end
    end
  end

  assign differs = {candTilt, candOrient, candFacing}
                   != {steepTiltFlag_r, screenOrientation_r, facingSide_r};

  // A differing candidate is taken once the counter has reached the count.
  assign doUpdate = evalNow && differs && (settleCnt_r >= settleCountValue_r); // R18 R11

  // An update, or the first evaluation after activation, raises the flag.
  assign newEvent = doUpdate || (evalNow && firstPending_r);

  // The counter saturates so a long settle count can never wrap to zero
  // and fire an early update; a wake or sleep change restarts settling.

  always_comb begin
    settleCnt_nxt = settleCnt_r;
    if (wakeSleepEdge) begin
      settleCnt_nxt = 8'h00; // R12
    end else if (evalNow) begin
      if (doUpdate) begin
        settleCnt_nxt = 8'h00;
      end else if (differs) begin
        settleCnt_nxt = (settleCnt_r == 8'hff) ? settleCnt_r : settleCnt_r + 8'h01;
      end else if (settleCounterMode_r) begin
        settleCnt_nxt = 8'h00; // R9
      end else if (settleCnt_r != 8'h00) begin
        settleCnt_nxt = settleCnt_r - 8'h01; // R9
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settleCnt_r <= 8'h00;
    end else if (ce) begin
      settleCnt_r <= settleCnt_nxt;
    end
  end

  // Mode edge detectors for wake/sleep and standby/active.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepDly_r <= 1'b0;
      activeDly_r <= 1'b0;
    end else if (ce) begin
      sleepDly_r <= sleepMode;
      activeDly_r <= activeMode;
    end
  end

  // First detection after entering active mode is still owed.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstPending_r <= 1'b0;
    end else if (ce) begin
      if (activeMode && !activeDly_r) begin
        firstPending_r <= 1'b1;
      end else if (!activeMode || evalNow) begin
        firstPending_r <= 1'b0;
      end
    end
  end

  // Reported fields follow updates regardless of the change flag.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      steepTiltFlag_r <= 1'b0; // R8
      screenOrientation_r <= odr_pkg::ODR_PORTRAIT_UP;
      facingSide_r <= 1'b0;
    end else if (ce && doUpdate) begin
      steepTiltFlag_r <= candTilt; // R3 R7
      screenOrientation_r <= candOrient; // R3
      facingSide_r <= candFacing; // R3
    end
  end

  // Change flag: a new event in the read cycle wins over the clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      orientationChangeFlag_r <= 1'b0; // R8
    end else if (ce) begin
      if (newEvent) begin
        orientationChangeFlag_r <= 1'b1; // R2
      end else if (statusRead) begin
        orientationChangeFlag_r <= 1'b0; // R1
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      orientationEvent <= 1'b0;
    end else if (ce) begin
      if (newEvent) begin
        orientationEvent <= 1'b1;
      end else if (statusRead) begin
        orientationEvent <= 1'b0; // R1
      end
    end
  end

  // Writable configuration; other offsets ignore writes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settleCounterMode_r <= odr_pkg::CFG_MODE_RESET; // R9
      orientationEnable_r <= odr_pkg::CFG_ENABLE_RESET; // R10
    end else if (wrConfig) begin
      settleCounterMode_r <= regWrData[odr_pkg::CFG_MODE_BIT];
      orientationEnable_r <= regWrData[odr_pkg::CFG_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settleCountValue_r <= odr_pkg::SETTLE_COUNT_RESET; // R11
    end else if (wrCount) begin
      settleCountValue_r <= regWrData; // R11
    end
  end

  // Read multiplexer; status reports the value before the clear.
  // Unused bits stay zero so hosts may compare whole bytes.
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      odr_pkg::ORIENTATION_STATUS: begin
        rdMux[odr_pkg::STAT_CHANGE_BIT] = orientationChangeFlag_r; // R19
        rdMux[odr_pkg::STAT_TILT_BIT] = steepTiltFlag_r;
        rdMux[odr_pkg::STAT_ORIENT_HI:odr_pkg::STAT_ORIENT_LO] = screenOrientation_r;
        rdMux[odr_pkg::STAT_FACING_BIT] = facingSide_r;
      end
      odr_pkg::ORIENTATION_CONFIG: begin
        rdMux[odr_pkg::CFG_MODE_BIT] = settleCounterMode_r;
        rdMux[odr_pkg::CFG_ENABLE_BIT] = orientationEnable_r;
      end
      odr_pkg::ORIENTATION_SETTLE_COUNT: begin
        rdMux = settleCountValue_r;
      end
      odr_pkg::FACING_AND_TILT_ANGLES: begin
        rdMux = {odr_pkg::FACING_TRIP_CODE, 3'h0, odr_pkg::STEEP_ANGLE_CODE}; // R14 R15
      end
      odr_pkg::ORIENTATION_THRESHOLD_HYSTERESIS: begin
        rdMux = {odr_pkg::ORIENTATION_TRIP_CODE, odr_pkg::ANGLE_MARGIN_CODE}; // R16
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settleStepUs <= odr_pkg::STEP_1250_US;
    end else if (ce) begin
      settleStepUs <= step_us(sampleRate, osMode); // R13
    end
  end

endmodule : orientation_detect_regs

// File: testbench/odr_regs_props.sv
// Port checker of the orientation block.
// Assumes it is bound to orientation_detect_regs and sees only its ports.
`timescale 1ns/10ps
module odr_regs_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic sampleStrobe,
  input wire logic [2:0] sampleRate,
  input wire logic [1:0] osMode,
  input wire logic orientationEvent,
  input wire logic [17:0] settleStepUs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_read_answered: assert property (ce && regRdEn |=> regRdValid)
    else $error("read not answered");
  chk_status_zeros: assert property (
    ce && regRdEn && regAddr == 8'h10 |=> regRdData[5:3] == 3'h0)
    else $error("status bits 5:3 not zero");
  chk_config_zeros: assert property (
    ce && regRdEn && regAddr == 8'h11 |=> regRdData[5:0] == 6'h00)
    else $error("config bits 5:0 not zero");
  chk_angle_codes: assert property (
    ce && regRdEn && regAddr == 8'h13 |=> regRdData == 8'h44)
    else $error("angle codes wrong");
  chk_trip_codes: assert property (
    ce && regRdEn && regAddr == 8'h14 |=> regRdData == 8'h84)
    else $error("trip codes wrong");
  chk_read_clears: assert property (
    ce && regRdEn && regAddr == 8'h10 && !sampleStrobe |=> !orientationEvent)
    else $error("event kept after status read");
  chk_event_cause: assert property ($rose(orientationEvent) |-> $past(sampleStrobe))
    else $error("event without sample");
  chk_event_holds: assert property (
    orientationEvent && !(regRdEn && regAddr == 8'h10) |=> orientationEvent)
    else $error("event dropped without read");
  chk_step_fast: assert property (sampleRate == 3'h0 |=> settleStepUs == 18'h004e2)
    else $error("fast step wrong");
  chk_step_hires: assert property (
    osMode == 2'h2 && sampleRate != 3'h0 |=> settleStepUs == 18'h009c4)
    else $error("high resolution step wrong");
endmodule : odr_regs_props

bind orientation_detect_regs odr_regs_props i_props (.clk, .rst_b, .ce, .regAddr,
  .regRdEn, .regRdData, .regRdValid, .sampleStrobe, .sampleRate, .osMode,
  .orientationEvent, .settleStepUs);

// File: testbench/odr_host_model.sv
// Host model issuing single-byte register reads and writes.
// Assumes one-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/10ps
module odr_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regWrData = ~v;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    v = regRdValid ? regRdData : 8'hxx;
  endtask : rd
endmodule : odr_host_model

// File: testbench/orientation_detect_regs_tb_top.sv
// Self-checking bench of the orientation block, random and corner stimulus.
// Assumes the host model owns the register port; the bench drives samples.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin badCount++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module orientation_detect_regs_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, d, q;
  logic regWrEn, regRdEn, regRdValid, orientationEvent;
  logic sampleStrobe = 1'b0, activeMode = 1'b0, sleepMode = 1'b0;
  logic portraitInverted = 1'b0, landscapeLeft = 1'b0, facingBackward = 1'b0;
  logic [2:0] sampleRate = 3'h0, axisOverRange = 3'h0;
  logic [1:0] osMode = 2'h0;
  logic [6:0] portraitAngle = 7'h5a, facingAngle = 7'h50, screenElevation = 7'h3c;
  logic [17:0] settleStepUs;
  int badCount = 0, checks = 0;
  logic [7:0] ad [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic [7:0] rv [6] = '{8'h00, 8'h80, 8'h00, 8'h44, 8'h84, 8'h00};

  always #5 clk = ~clk;

  orientation_detect_regs i_dut (.clk, .rst_b, .ce, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdValid, .sampleStrobe, .activeMode, .sleepMode,
    .sampleRate, .osMode, .axisOverRange, .portraitAngle, .portraitInverted,
    .landscapeLeft, .facingAngle, .facingBackward, .screenElevation,
    .orientationEvent, .settleStepUs);
  odr_host_model i_host (.clk, .regRdData, .regRdValid, .regAddr, .regWrEn,
    .regWrData, .regRdEn);

  function automatic logic [7:0] stat(input logic n, t, input logic [1:0] o, input logic f);
    return {n, t, 3'h0, o, f};
  endfunction : stat

  function automatic logic [17:0] stepExp(input logic [2:0] r, input logic [1:0] m);
    if (r == odr_pkg::RATE_800) return odr_pkg::STEP_1250_US;
    if (r == odr_pkg::RATE_400 || m == odr_pkg::ODR_OS_HIGH_RES) return odr_pkg::STEP_2500_US;
    if (r == odr_pkg::RATE_200) return odr_pkg::STEP_5000_US;
    if (r == odr_pkg::RATE_100) return odr_pkg::STEP_10000_US;
    if (r == odr_pkg::RATE_50 || m == odr_pkg::ODR_OS_NORMAL) return odr_pkg::STEP_20000_US;
    if (m == odr_pkg::ODR_OS_LOW_POWER && r > odr_pkg::RATE_12P5) return odr_pkg::STEP_160000_US;
    return odr_pkg::STEP_80000_US;
  endfunction : stepExp

  task summarize;
    if (badCount == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task smp(input logic [6:0] a, input logic [6:0] e, input int n = 1);
    repeat (n) begin
      @(negedge clk);
      portraitAngle = a;
      screenElevation = e;
      sampleStrobe = 1'b1;
      @(negedge clk);
      sampleStrobe = 1'b0;
    end
  endtask : smp

  task st(input logic [7:0] e);
    i_host.rd(8'h10, q);
    `CHK("status", e, q)
  endtask : st

  initial begin
    void'($urandom(74638));
    repeat (12) @(posedge clk);
    `CHK("step", odr_pkg::STEP_1250_US, settleStepUs)
    @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      i_host.rd(ad[i], q);
      `CHK("reset value", rv[i], q)
    end
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      i_host.wr(ad[i], d);
      i_host.rd(ad[i], q);
      `CHK("written", ad[i] == 8'h11 ? {d[7:6], 6'h00} : ad[i] == 8'h12 ? d : rv[i], q)
    end
    i_host.wr(8'h11, 8'h80);
    i_host.wr(8'h12, 8'h00);
    activeMode = 1'b1;
    smp(7'd20, 7'd60);
    st(8'h00);
    i_host.wr(8'h11, 8'hc0);
    smp(7'd90, 7'd60);
    `CHK("event", 1'b1, orientationEvent)
    st(stat(1, 0, 2'h0, 0));
    st(8'h00);
    `CHK("event", 1'b0, orientationEvent)
    landscapeLeft = 1'b1;
    smp(7'd20, 7'd60);
    st(stat(1, 0, 2'h3, 0));
    smp(7'd40, 7'd60);
    st(stat(0, 0, 2'h3, 0));
    portraitInverted = 1'b1;
    smp(7'd60, 7'd60);
    smp(7'd31, 7'd60);
    st(stat(1, 0, 2'h1, 0));
    landscapeLeft = 1'b0;
    smp(7'd30, 7'd60);
    facingBackward = 1'b1;
    smp(7'd30, 7'd60);
    st(stat(1, 0, 2'h2, 1));
    axisOverRange = 3'($urandom_range(7, 1));
    facingBackward = 1'b0;
    smp(7'd90, 7'd10);
    axisOverRange = 3'h0;
    st(stat(0, 0, 2'h2, 1));
    smp(7'd90, 7'd10);
    st(stat(1, 1, 2'h2, 0));
    smp(7'd90, 7'd60);
    st(stat(1, 0, 2'h1, 0));
    i_host.wr(8'h12, 8'h02);
    smp(7'd20, 7'd60, 2);
    smp(7'd90, 7'd60);
    smp(7'd20, 7'd60, 2);
    st(stat(0, 0, 2'h1, 0));
    smp(7'd20, 7'd60);
    st(stat(1, 0, 2'h2, 0));
    i_host.wr(8'h11, 8'h40);
    smp(7'd90, 7'd60, 2);
    smp(7'd20, 7'd60);
    smp(7'd90, 7'd60, 2);
    st(stat(1, 0, 2'h1, 0));
    smp(7'd20, 7'd60, 2);
    sleepMode = 1'b1;
    smp(7'd20, 7'd60, 2);
    smp(7'd90, 7'd60);
    st(stat(0, 0, 2'h1, 0));
    i_host.wr(8'h12, 8'h00);
    facingAngle = 7'd70;
    facingBackward = 1'b1;
    smp(7'd90, 7'd60);
    st(stat(0, 0, 2'h1, 0));
    facingAngle = 7'd80;
    @(negedge clk);
    ce = 1'b0;
    smp(7'd90, 7'd60);
    @(negedge clk);
    ce = 1'b1;
    st(stat(0, 0, 2'h1, 0));
    smp(7'd90, 7'd60);
    st(stat(1, 0, 2'h1, 1));
    repeat (24) begin
      @(negedge clk);
      sampleRate = 3'($urandom);
      osMode = 2'($urandom);
      @(negedge clk);
      `CHK("step", stepExp(sampleRate, osMode), settleStepUs)
    end
    summarize();
  end

  initial begin
    #300000;
    badCount++;
    summarize();
  end
endmodule : orientation_detect_regs_tb_top
